// ---- dtc_term_ctrl.sv ----
// dynamic termination control: latency pipeline, strength selection, register port
// assumes the link clock and pins arrive from outside and are sampled by clk_sys_i
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module dtc_term_ctrl
   import dtc_pkg::*;
#(
   parameter int MAX_LAT = DTC_MAX_LAT_DEF
) (
   input  wire logic            clk_sys_i,
   input  wire logic            arst_n_i,
   input  dtc_bus_req_type      bus_req_i,
   output logic     [31:0]      bus_rdata_o,
   input  dtc_pins_type         pins_i,
   output logic                 term_on_o,
   output logic                 term_sel_write_o,
   output logic     [2:0]       term_value_o
);

   localparam int HW = 3 * (MAX_LAT + 1);

   // ****************************************
   // parameter check
   // ****************************************
   if (MAX_LAT < 3 || MAX_LAT > 30) begin : g_chk
      $error("dtc_term_ctrl needs MAX_LAT between 3 and 30");
   end

   // ****************************************
   // functions
   // ****************************************
   function automatic logic [4:0] calc_lat(input logic [7:0] cfg);
      logic [4:0] sum;
      sum = 5'(cfg[DTC_CWL_LSB +: 4]) + 5'(cfg[DTC_AL_LSB +: 4]);
      if (sum <= DTC_LAT_OFFSET + DTC_LAT_MIN) begin
         return DTC_LAT_MIN;
      end
      if (sum - DTC_LAT_OFFSET > 5'(MAX_LAT)) begin
         return 5'(MAX_LAT);
      end
      return sum - DTC_LAT_OFFSET;
   endfunction

   function automatic logic [2:0] pick_entry(input logic [HW-1:0] h, input logic [4:0] idx);
      return h[int'(idx) * 3 +: 3];
   endfunction

   function automatic logic [2:0] nom_field(input logic [15:0] m);
      return {m[DTC_NOM_BIT_HI], m[DTC_NOM_BIT_MID], m[DTC_NOM_BIT_LO]};
   endfunction

   function automatic logic [1:0] wr_field(input logic [15:0] m);
      return {m[DTC_WR_BIT_HI], m[DTC_WR_BIT_LO]};
   endfunction

   // ****************************************
   // state and decoded terms
   // ****************************************
   dtc_state_type st;
   dtc_state_type next_st;

   logic            rise;
   logic            fall;
   logic            dyn_en;
   logic            term_en;
   logic [4:0]      lat;
   logic [2:0]      ent;
   logic [2:0]      sample;
   logic [HW-1:0]   hist;

   assign rise    = st.sync2[DTC_SY_CLK] & ~st.link_prev;
   assign fall    = ~st.sync2[DTC_SY_CLK] & st.link_prev;
   assign dyn_en  = |wr_field(st.mode_two);
   assign term_en = (|nom_field(st.mode_one)) | dyn_en;
   assign lat     = calc_lat(st.lat_cfg);
   // the entry at lat-1 is the sample that turns lat link cycles old at this edge
   assign ent     = pick_entry(hist, lat - DTC_LAT_MIN);
   // self-refresh blanks the pin and write samples so no pin or write sampled during it survives it
   assign sample  = {st.sync2[DTC_SY_CHOP],
                     st.sync2[DTC_SY_WR] & dyn_en & ~st.self_refresh,
                     st.sync2[DTC_SY_PIN] & ~st.self_refresh};

   dtc_history #(
      .WIDTH (3),
      .DEPTH (MAX_LAT + 1)
   ) u_hist (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .shift_i   (rise),
      .din_i     (sample),
      .hist_o    (hist)
   );

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      next_st = st;
      next_st.sync1     = {pins_i.chop, pins_i.write_cmd, pins_i.term_pin, pins_i.link_clk};
      next_st.sync2     = st.sync1;
      next_st.link_prev = st.sync2[DTC_SY_CLK];
      next_st.rdata     = 32'h0000_0000;

      // register port
      if (bus_req_i.wr) begin
         unique case (bus_req_i.addr)
            DTC_OFS_MODE_ONE: next_st.mode_one = bus_req_i.wdata[15:0];
            DTC_OFS_MODE_TWO: next_st.mode_two = bus_req_i.wdata[15:0];
            DTC_OFS_LAT_CFG:  next_st.lat_cfg  = bus_req_i.wdata[7:0];
            DTC_OFS_CTRL:     next_st.self_refresh = bus_req_i.wdata[DTC_CTRL_SR_BIT];
            default: ;
         endcase
      end
      if (bus_req_i.rd) begin
         unique case (bus_req_i.addr)
            DTC_OFS_MODE_ONE: next_st.rdata = {16'h0000, st.mode_one};
            DTC_OFS_MODE_TWO: next_st.rdata = {16'h0000, st.mode_two};
            DTC_OFS_LAT_CFG:  next_st.rdata = {24'h00_0000, st.lat_cfg};
            DTC_OFS_CTRL:     next_st.rdata = {31'h0000_0000, st.self_refresh};
            DTC_OFS_STATUS:   next_st.rdata = {22'h00_0000, lat, st.value, st.sel_write, st.term_on};
            default:          next_st.rdata = 32'h0000_0000;
         endcase
      end

      // targets move on the link rising edge that ends the latency
      if (rise) begin
         next_st.target_on = ent[0] & term_en;
         if (ent[1]) begin
            next_st.target_sel = 1'b1;
            next_st.hold_cnt   = ent[2] ? DTC_HOLD_CHOP : DTC_HOLD_FULL;
         end else if (st.hold_cnt != 3'h0) begin
            next_st.hold_cnt = st.hold_cnt - 3'h1;
            if (st.hold_cnt == 3'h1) begin
               next_st.target_sel = 1'b0;
            end
         end
      end

      // applied half a link cycle later, on the falling edge
      if (fall) begin
         next_st.term_on   = st.target_on;
         next_st.sel_write = st.target_sel;
      end

      if (st.self_refresh) begin
         next_st.target_on = 1'b0;
         next_st.term_on   = 1'b0;
      end

      next_st.value = st.sel_write ? {1'b0, wr_field(st.mode_two)}
                                   : nom_field(st.mode_one);
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st          <= '0;
         st.mode_one <= DTC_RST_MODE_ONE;
         st.mode_two <= DTC_RST_MODE_TWO;
         st.lat_cfg  <= DTC_RST_LAT_CFG;
      end else begin
         st <= next_st;
      end
   end

   assign bus_rdata_o      = st.rdata;
   assign term_on_o        = st.term_on;
   assign term_sel_write_o = st.sel_write;
   assign term_value_o     = st.value;

   // ****************************************
   // assertions
   // ****************************************
   default clocking dtc_cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!arst_n_i);

   property p_dyn_gate;
      rise && st.sync2[DTC_SY_WR] && !dyn_en |=> !hist[1];
   endproperty
   a_dyn_gate: assert property (p_dyn_gate) else $error("write sampled with dynamic switching off");

   property p_nom_value;
      !st.sel_write |=> term_value_o == nom_field($past(st.mode_one));
   endproperty
   a_nom_value: assert property (p_nom_value) else $error("nominal value does not match mode one");

   property p_wr_value;
      st.sel_write |=> term_value_o == {1'b0, wr_field($past(st.mode_two))};
   endproperty
   a_wr_value: assert property (p_wr_value) else $error("write value does not match mode two");

   property p_on_follows;
      fall && !st.self_refresh |=> term_on_o == $past(st.target_on);
   endproperty
   a_on_follows: assert property (p_on_follows) else $error("termination state not taken at fall");

   property p_on_latency;
      rise && !st.self_refresh |=> st.target_on == ($past(ent[0]) && $past(term_en));
   endproperty
   a_on_latency: assert property (p_on_latency) else $error("termination target ignores delayed pin");

   property p_lat_sum;
      (5'(st.lat_cfg[3:0]) + 5'(st.lat_cfg[7:4]) == 5'h05) |-> lat == 5'h03;
   endproperty
   a_lat_sum: assert property (p_lat_sum) else $error("latency is not cwl plus al minus two");

   property p_sel_write;
      rise && ent[1] |=> st.target_sel ##1 st.target_sel;
   endproperty
   a_sel_write: assert property (p_sel_write) else $error("write strength not selected");

   property p_chop;
      rise && ent[1] && ent[2] |=> st.hold_cnt == DTC_HOLD_CHOP;
   endproperty
   a_chop: assert property (p_chop) else $error("chop write hold count wrong");

   property p_full;
      rise && ent[1] && !ent[2] |=> st.hold_cnt == DTC_HOLD_FULL;
   endproperty
   a_full: assert property (p_full) else $error("full write hold count wrong");

   property p_back;
      rise && !ent[1] && st.hold_cnt == 3'h1 |=> !st.target_sel && st.hold_cnt == 3'h0;
   endproperty
   a_back: assert property (p_back) else $error("strength did not return to nominal");

   property p_skew;
      $changed(term_sel_write_o) || $changed(term_on_o) && !$past(st.self_refresh) |-> $past(fall);
   endproperty
   a_skew: assert property (p_skew) else $error("strength or state changed off the falling edge");

   property p_disabled;
      !term_en && rise |=> !st.target_on;
   endproperty
   a_disabled: assert property (p_disabled) else $error("termination on while disabled");

   property p_self_refresh;
      st.self_refresh |=> !term_on_o && !st.target_on;
   endproperty
   a_self_refresh: assert property (p_self_refresh) else $error("termination on in self-refresh");

   property p_off_select;
      !st.target_on && fall ##1 (term_sel_write_o != $past(term_sel_write_o)) |-> !term_on_o;
   endproperty
   a_off_select: assert property (p_off_select) else $error("strength change turned termination on");

   // ****************************************
   // register port and quiet-time checks
   // ****************************************

   property p_wr_mode_one;
      bus_req_i.wr && bus_req_i.addr == DTC_OFS_MODE_ONE |=> st.mode_one == $past(bus_req_i.wdata[15:0]);
   endproperty
   a_wr_mode_one: assert property (p_wr_mode_one) else $error("mode one write not taken");

   property p_wr_mode_two;
      bus_req_i.wr && bus_req_i.addr == DTC_OFS_MODE_TWO |=> st.mode_two == $past(bus_req_i.wdata[15:0]);
   endproperty
   a_wr_mode_two: assert property (p_wr_mode_two) else $error("mode two write not taken");

   property p_wr_lat;
      bus_req_i.wr && bus_req_i.addr == DTC_OFS_LAT_CFG |=> st.lat_cfg == $past(bus_req_i.wdata[7:0]);
   endproperty
   a_wr_lat: assert property (p_wr_lat) else $error("latency setting write not taken");

   property p_wr_ctrl;
      bus_req_i.wr && bus_req_i.addr == DTC_OFS_CTRL |=> st.self_refresh == $past(bus_req_i.wdata[DTC_CTRL_SR_BIT]);
   endproperty
   a_wr_ctrl: assert property (p_wr_ctrl) else $error("self-refresh write not taken");

   property p_rd_mode_one;
      bus_req_i.rd && bus_req_i.addr == DTC_OFS_MODE_ONE |=> bus_rdata_o == {16'h0000, $past(st.mode_one)};
   endproperty
   a_rd_mode_one: assert property (p_rd_mode_one) else $error("mode one read wrong");

   property p_rd_mode_two;
      bus_req_i.rd && bus_req_i.addr == DTC_OFS_MODE_TWO |=> bus_rdata_o == {16'h0000, $past(st.mode_two)};
   endproperty
   a_rd_mode_two: assert property (p_rd_mode_two) else $error("mode two read wrong");

   property p_rd_lat;
      bus_req_i.rd && bus_req_i.addr == DTC_OFS_LAT_CFG |=> bus_rdata_o == {24'h00_0000, $past(st.lat_cfg)};
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("latency setting read wrong");

   property p_rd_ctrl;
      bus_req_i.rd && bus_req_i.addr == DTC_OFS_CTRL |=> bus_rdata_o == {31'h0000_0000, $past(st.self_refresh)};
   endproperty
   a_rd_ctrl: assert property (p_rd_ctrl) else $error("self-refresh read wrong");

   property p_rd_status;
      bus_req_i.rd && bus_req_i.addr == DTC_OFS_STATUS |=>
         bus_rdata_o == {22'h00_0000, $past(lat), $past(st.value), $past(st.sel_write), $past(st.term_on)};
   endproperty
   a_rd_status: assert property (p_rd_status) else $error("status read wrong");

   property p_rd_idle;
      !bus_req_i.rd |=> bus_rdata_o == 32'h0000_0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside a read");

   property p_lat_range;
      lat >= DTC_LAT_MIN && lat <= 5'(MAX_LAT);
   endproperty
   a_lat_range: assert property (p_lat_range) else $error("latency outside pipeline depth");

   property p_sel_hold;
      st.target_sel == (st.hold_cnt != 3'h0);
   endproperty
   a_sel_hold: assert property (p_sel_hold) else $error("write strength without hold count");

   property p_hold_quiet;
      !rise |=> $stable(st.hold_cnt);
   endproperty
   a_hold_quiet: assert property (p_hold_quiet) else $error("hold count moved off a link edge");

   property p_sel_quiet;
      !rise |=> $stable(st.target_sel);
   endproperty
   a_sel_quiet: assert property (p_sel_quiet) else $error("strength target moved off a link edge");

   property p_on_quiet;
      !rise && !st.self_refresh |=> $stable(st.target_on);
   endproperty
   a_on_quiet: assert property (p_on_quiet) else $error("termination target moved off a link edge");

   property p_out_quiet;
      !fall && !st.self_refresh |=> $stable(term_on_o) && $stable(term_sel_write_o);
   endproperty
   a_out_quiet: assert property (p_out_quiet) else $error("outputs moved off a falling link edge");

   property p_link_edge;
      rise |=> !rise;
   endproperty
   a_link_edge: assert property (p_link_edge) else $error("one link edge seen twice");

   property p_sr_blank;
      st.self_refresh && rise |=> !hist[0] && !hist[1];
   endproperty
   a_sr_blank: assert property (p_sr_blank) else $error("pin or write recorded in self-refresh");

   c_chop_write: cover property (rise && ent[1] && ent[2]);
   c_full_write: cover property (rise && ent[1] && !ent[2]);
   c_term_on: cover property (!term_on_o ##1 term_on_o);
   c_write_while_on: cover property (term_on_o && term_sel_write_o);
   c_sr_entry: cover property (term_on_o ##1 st.self_refresh);

endmodule

// ---- dtc_pkg.sv ----
// constants, field layouts and carrier types of the dynamic termination control
// assumes the register port and the sampled pins of the termination block
// Summary of operation
// - dynamic switching is on when either write-termination bit of mode register two is one
// - nominal strength comes from mode register one bits 9, 6 and 2
// - write strength comes from mode register two bits 10 and 9
// - outside writes the nominal strength is applied whenever termination is on
// - outside self-refresh termination turns on and off only as the control pin directs, after latency
// - on and off latency equal write latency minus two, from the registering edge
// - a write with dynamic switching selects write strength after write latency minus two
// - a chop write returns to nominal four cycles plus off latency after the command
// - a full burst write returns to nominal six cycles plus off latency after it
// - a new strength becomes valid about half a clock after its latency expires
// - pin low means off; pin high means on unless both mode fields disable it
// - the latency used is cas write latency plus additive latency minus two
// - during self-refresh termination is off and the control pin is ignored
package dtc_pkg;

   // ****************************************
   // register offsets and reset values
   // ****************************************
   localparam logic [7:0]  DTC_OFS_MODE_ONE = 8'h00;
   localparam logic [7:0]  DTC_OFS_MODE_TWO = 8'h04;
   localparam logic [7:0]  DTC_OFS_LAT_CFG  = 8'h08;
   localparam logic [7:0]  DTC_OFS_CTRL     = 8'h0c;
   localparam logic [7:0]  DTC_OFS_STATUS   = 8'h10;
   localparam logic [15:0] DTC_RST_MODE_ONE = 16'h0000;
   localparam logic [15:0] DTC_RST_MODE_TWO = 16'h0000;
   localparam logic [7:0]  DTC_RST_LAT_CFG  = 8'h05;

   // ****************************************
   // field positions
   // ****************************************
   localparam int DTC_NOM_BIT_HI  = 9;
   localparam int DTC_NOM_BIT_MID = 6;
   localparam int DTC_NOM_BIT_LO  = 2;
   localparam int DTC_WR_BIT_HI   = 10;
   localparam int DTC_WR_BIT_LO   = 9;
   localparam int DTC_CWL_LSB     = 0;
   localparam int DTC_AL_LSB      = 4;
   localparam int DTC_CTRL_SR_BIT = 0;
   localparam int DTC_SY_CLK      = 0;
   localparam int DTC_SY_PIN      = 1;
   localparam int DTC_SY_WR       = 2;
   localparam int DTC_SY_CHOP     = 3;

   // ****************************************
   // timing counts in link clock cycles
   // ****************************************
   localparam logic [4:0] DTC_LAT_OFFSET  = 5'h02;
   localparam logic [4:0] DTC_LAT_MIN     = 5'h01;
   localparam logic [2:0] DTC_HOLD_CHOP   = 3'h4;
   localparam logic [2:0] DTC_HOLD_FULL   = 3'h6;
   localparam int         DTC_MAX_LAT_DEF = 16;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } dtc_bus_req_type;

   typedef struct packed {
      logic chop;
      logic write_cmd;
      logic term_pin;
      logic link_clk;
   } dtc_pins_type;

   typedef struct packed {
      logic [3:0]  sync1;
      logic [3:0]  sync2;
      logic        link_prev;
      logic [15:0] mode_one;
      logic [15:0] mode_two;
      logic [7:0]  lat_cfg;
      logic        self_refresh;
      logic [31:0] rdata;
      logic        target_on;
      logic        target_sel;
      logic [2:0]  hold_cnt;
      logic        term_on;
      logic        sel_write;
      logic [2:0]  value;
   } dtc_state_type;

endpackage

// ---- dtc_history.sv ----
// shift history of per-link-cycle samples, newest in the lowest slot
// assumes shift_i is a one-cycle pulse on each link clock rising edge
`timescale 1ns/1ps
module dtc_history
   import dtc_pkg::*;
#(
   parameter int WIDTH = 3,
   parameter int DEPTH = DTC_MAX_LAT_DEF
) (
   input  wire logic                   clk_sys_i,
   input  wire logic                   arst_n_i,
   input  wire logic                   shift_i,
   input  wire logic [WIDTH-1:0]       din_i,
   output logic      [WIDTH*DEPTH-1:0] hist_o
);

   typedef struct packed {
      logic [WIDTH*DEPTH-1:0] vec;
   } dtc_hist_state_type;

   dtc_hist_state_type st;
   dtc_hist_state_type next_st;

   if (WIDTH < 1 || DEPTH < 2) begin : g_chk
      $error("dtc_history needs WIDTH of one or more and DEPTH of two or more");
   end

   always_comb begin
      next_st = st;
      if (shift_i) begin
         next_st.vec = {st.vec[WIDTH*(DEPTH-1)-1:0], din_i};
      end
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign hist_o = st.vec;

endmodule

// ---- dtc_ctrl_model.sv ----
// memory controller model: free-running link clock, termination pin, write and chop pins
// assumes the bench calls cycle once per link clock; pins change just after the link falling edge
`timescale 1ns/1ps
module dtc_ctrl_model (
   input  wire logic clk_sys_i,
   output logic      link_clk_o,
   output logic      term_pin_o,
   output logic      write_cmd_o,
   output logic      chop_o
);
   int hold;

   initial begin
      link_clk_o = 0;
      term_pin_o = 0;
      write_cmd_o = 0;
      chop_o = 0;
      hold = 0;
      #7;
      forever #100 link_clk_o = ~link_clk_o;
   end

   // ****************
   // one link cycle; a pin request is stretched to meet the hold times
   // ****************
   task automatic cycle(input bit p, input bit w, input bit c);
      bit pa;
      int hn;
      @(negedge link_clk_o);
      @(posedge clk_sys_i);
      pa = p | (hold != 0);
      hn = (hold != 0) ? hold - 1 : 0;
      if (pa && !term_pin_o) hn = 3;
      if (pa && w && hn < (c ? 3 : 5)) hn = c ? 3 : 5;
      hold = hn;
      term_pin_o <= pa;
      write_cmd_o <= w;
      // chop is meaningless without a write, so it wanders
      chop_o <= w ? c : ~chop_o;
   endtask
endmodule

// ---- tb_top.sv ----
// testbench of the termination control against a behavioural model
// assumes the controller model drives the link pins and runs the link clock
`timescale 1ns/1ps
module tb_top;
   import dtc_pkg::*;
   logic            clk_sys_i;
   logic            arst_n_i;
   dtc_bus_req_type req;
   dtc_pins_type    pins;
   logic [31:0]     rdata;
   logic            t_on;
   logic            t_sel;
   logic [2:0]      t_val;
   logic            lk, pn, wr, ch;
   int              num_errors, check_count, cyc, lat, seed, idx;
   bit              sr, chk_en;
   bit [15:0]       mr1, mr2;
   bit [7:0]        lcfg;
   bit [1:0]        e_old, e_last;
   bit              pin_h[$], wr_h[$], ch_h[$];
   bit [7:0]        cfg[6] = '{8'h05, 8'h35, 8'h02, 8'hff, 8'h05, 8'h16};

   assign pins = {ch, wr, pn, lk};
   dtc_term_ctrl dtc_term_ctrl_i (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .bus_req_i(req),
      .bus_rdata_o(rdata), .pins_i(pins), .term_on_o(t_on), .term_sel_write_o(t_sel), .term_value_o(t_val));
   dtc_ctrl_model dtc_ctrl_model_i (.clk_sys_i(clk_sys_i), .link_clk_o(lk), .term_pin_o(pn),
      .write_cmd_o(wr), .chop_o(ch));

   initial begin
      clk_sys_i = 0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end

   // ****************
   // reporting, compares and register access
   // ****************
   task automatic final_report;
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic bad(input string m);
      num_errors++;
      $display("unexpected at %0t: %s", $time, m);
   endtask

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) bad($sformatf("read %h exp %h", got, exp));
   endtask

   task automatic chk_term(input bit on, input bit sel);
      logic [2:0] v;
      v = sel ? {1'b0, mr2[10:9]} : {mr1[9], mr1[6], mr1[2]};
      check_count++;
      if ({t_on, t_sel, t_val} !== {on, sel, v}) bad($sformatf("term %b%b%h exp %b%b%h", t_on, t_sel, t_val, on, sel, v));
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_sys_i);
      req <= '0;
      case (a)
         DTC_OFS_MODE_ONE: mr1 = d[15:0];
         DTC_OFS_MODE_TWO: mr2 = d[15:0];
         DTC_OFS_LAT_CFG: lcfg = d[7:0];
         DTC_OFS_CTRL: sr = d[0];
         default: ;
      endcase
      lat = int'(lcfg[3:0]) + int'(lcfg[7:4]) - 2;
      lat = lat < 1 ? 1 : (lat > DTC_MAX_LAT_DEF ? DTC_MAX_LAT_DEF : lat);
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_sys_i);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge clk_sys_i);
      req <= '0;
      #1 chk32(rdata, exp);
   endtask

   // ****************
   // model: per link edge history, expectation for the edge lat cycles back
   // ****************
   always @(posedge lk) begin
      int i;
      bit on, sel;
      pin_h.push_back(pn & ~sr);
      wr_h.push_back(wr & ~sr & (mr2[10] | mr2[9]));
      ch_h.push_back(ch);
      i = pin_h.size() - 1 - lat;
      on = 0;
      sel = 0;
      if (i >= 0) begin
         on = pin_h[i] && ({mr1[9], mr1[6], mr1[2]} != 0 || mr2[10:9] != 0) && !sr;
         for (int k = i; k >= 0 && k > i - 6; k--) begin
            if (wr_h[k]) begin
               sel = (i - k) < (ch_h[k] ? 4 : 6);
               break;
            end
         end
      end
      e_old = e_last;
      e_last = {on, sel};
   end

   always @(negedge lk) if (chk_en) chk_term(e_old[1], e_old[0]);

   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 20000) begin
         bad("timeout");
         final_report();
      end
   end

   // ****************
   // main sequence
   // ****************
   initial begin
      arst_n_i = 0;
      req = '0;
      mr1 = 0;
      mr2 = 0;
      lcfg = 8'h05;
      lat = 3;
      seed = $urandom(28991);
      repeat (6) @(posedge clk_sys_i);
      arst_n_i <= 1;
      reg_rd(DTC_OFS_LAT_CFG, 32'h05);
      reg_rd(DTC_OFS_MODE_TWO, 32'h0);
      reg_rd(DTC_OFS_STATUS, 32'h60);
      reg_wr(DTC_OFS_MODE_ONE, 32'hffffffff);
      reg_rd(DTC_OFS_MODE_ONE, 32'h0000ffff);
      reg_wr(8'h14, 32'hffffffff);
      reg_rd(8'h14, 32'h0);
      for (idx = 0; idx < 6; idx++) begin
         chk_en = 0;
         reg_wr(DTC_OFS_LAT_CFG, {24'h0, cfg[idx]});
         // run 4 has both strength fields zero, run 5 is in self-refresh
         reg_wr(DTC_OFS_MODE_ONE, $urandom & (idx == 4 ? 32'hfdbb : 32'hffff));
         reg_wr(DTC_OFS_MODE_TWO, ($urandom & 32'hf9ff) | 32'(idx % 4) << 9);
         reg_wr(DTC_OFS_CTRL, 32'(idx == 5));
         reg_rd(DTC_OFS_STATUS, {22'h0, lat[4:0], mr1[9], mr1[6], mr1[2], 2'b00});
         repeat (2) dtc_ctrl_model_i.cycle(0, 0, 0);
         chk_en = 1;
         repeat (50) dtc_ctrl_model_i.cycle($urandom % 3 != 0, $urandom % 4 == 0, $urandom % 2);
         // drain the deepest latency so a longer one set next finds a quiet history
         repeat (DTC_MAX_LAT_DEF + 8) dtc_ctrl_model_i.cycle(0, 0, 0);
      end
      reg_wr(DTC_OFS_MODE_TWO, 32'h0);
      final_report();
   end
endmodule
